// file: src/sysctl_params.svh
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define TMODE_IDX 8'hf1
`define CNT1_IDX 8'hf2
`define PSC1_IDX 8'hf3
`define CNT0_IDX 8'hf4
`define PSC0_IDX 8'hf5
`define P2DIR_IDX 8'hf6
`define PRIO_IDX 8'hf9
`define IRQ_IDX 8'hfa
`define MASK_IDX 8'hfb
`define CMD_IDX 8'he0
`define STATUS_IDX 8'he1
`define P2DATA_IDX 8'he2

// Reset values.
`define TMODE_RESET 8'h00
`define P2DIR_RESET 8'hff
`define IRQ_RESET 8'h00
`define MASK_RESET 8'h00

// Field positions.
`define TMODE_LOAD0 0
`define TMODE_RUN0 1
`define TMODE_LOAD1 2
`define TMODE_RUN1 3
`define TMODE_TIN_LO 4
`define TMODE_TIN_HI 5
`define PRE_CONT 0
`define PRE_SRC_INT 1
`define PRE_MOD_LO 2
`define PRE_MOD_HI 7
`define IRQ_EDGE_B 1
`define IRQ_EDGE_A 2
`define IRQ_CNT0 4
`define IRQ_CNT1 5
`define MASK_GLOBAL 7
`define P2_WAKE_BIT 7

// Command opcodes written to the command register.
`define OP_WDT 8'h5f
`define OP_STOP 8'h6f
`define OP_HALT 8'h7f
`define OP_KEEP 8'h4f

// Vector byte addresses, one per source.
`define VEC_EDGE_B 4'h2
`define VEC_EDGE_A 4'h4
`define VEC_CNT0 4'h8
`define VEC_CNT1 4'ha

// Timing.
`define CLK_MHZ 200
`define WDT_TIMEOUT_MS 24
`define POR_TIME_MS 6
`define POR_EXTRA_CYCLES 18
`define WDT_CYCLES (`WDT_TIMEOUT_MS * 1000 * `CLK_MHZ)
`define POR_CYCLES (`POR_TIME_MS * 1000 * `CLK_MHZ + `POR_EXTRA_CYCLES)
`define WAKE_MIN_CYCLES 4

`endif

// file: src/sysctl_pkg.sv
`default_nettype none
package sysctl_pkg;
   typedef enum logic [1:0] {SLEEP_RUN, SLEEP_HALT, SLEEP_STOP} sleep_t;
   typedef enum logic [1:0] {TIN_EXT_CLOCK, TIN_GATE, TIN_TRIG_ONCE, TIN_TRIG_RETRIG} tin_mode_t;
endpackage
`default_nettype wire

// file: src/sysctl_core.sv
`include "sysctl_params.svh"
`default_nettype none

// Summary of operation
// - Each counter can be started, stopped, resumed, or restarted from its initial value.
// - Each counter runs single pass, halting at zero, or continuous with auto reload.
// - Prescaler modulo field divides by 1 to 64; zero means 64.
// - Counter values read without disturbing counting; prescalers are not readable.
// - Counter one clocks from processor clock over four or the external timer input.
// - Timer input acts as external clock, retriggerable, one-shot trigger, or gate.
// - Four sources: falling edges on both input pins and both counters.
// - Mask enables each request individually and all together through a global bit.
// - Priority select register picks which pending request is serviced first.
// - A grant clears global enable; core saves state and fetches a 16-bit vector.
// - Vector pairs are 2,3 edge b; 4,5 edge a; 8,9 counter zero; 10,11 counter one.
// - Pending bits latch even when masked so software can poll them.
// - HALT stops the CPU clock; counters and edge interrupts stay active.
// - An enabled interrupt ends HALT; execution continues after the HALT.
// - Reset or watchdog timeout also ends HALT, restarting from the reset address.
// - A keepalive command keeps the watchdog running during HALT.
// - STOP freezes the clock and watchdog; a long low wake pin ends it if armed.
// - Waking from STOP by the wake pin keeps the port mode registers.
// - During STOP and HALT the port two output and direction lines keep their levels.
// - Watchdog starts at its first command and only reset can disable it.
// - Watchdog command clears it; 24 ms without clear forces a 6 ms plus 18 cycle reset.
// - Counters decrement 1 to 256 per prescaler output; joint end raises the request.
module sysctl_core #(
   parameter int unsigned ADDR_W = 12,
   parameter int unsigned WDT_CYCLES = `WDT_CYCLES,
   parameter int unsigned POR_CYCLES = `POR_CYCLES,
   parameter int unsigned WAKE_MIN_CYCLES = `WAKE_MIN_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_input_pin,
   input wire logic second_edge_irq_pin,
   input wire logic stop_wake_pin,
   input wire logic int_ack,
   output logic int_request,
   output logic [3:0] int_vector,
   output logic cpu_clock_run,
   output logic core_reset,
   output logic [7:0] port_two_out,
   output logic [7:0] port_two_oe
);
   import sysctl_pkg::*;

   // Refuse settings the counters and decoder cannot serve.
   initial begin
      if (ADDR_W < 11 || WDT_CYCLES < 2 || POR_CYCLES < 2 || WAKE_MIN_CYCLES < 1 ||
          WAKE_MIN_CYCLES > 255) begin
         $error("sysctl_core: unsupported parameter value");
      end
   end

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [7:0] tmode;
      logic [1:0][7:0] init;
      logic [1:0][7:0] cnt;
      logic [1:0][7:0] pre;
      logic [1:0][5:0] pcnt;
      logic [1:0] div;
      logic [7:0] oe;
      logic [7:0] port_out;
      logic [7:0] prio;
      logic [7:0] irq;
      logic [7:0] mask;
      logic tin_prev;
      logic edge_b_prev;
      sleep_t sleep;
      logic run_out;
      logic wake_armed;
      logic [7:0] wake_cnt;
      logic wdt_on;
      logic wdh_on;
      logic [31:0] wd_cnt;
      logic [31:0] hold_cnt;
      logic core_reset;
      logic int_request;
      logic [3:0] vector;
      logic [1:0] slot;
   } state_t;

   state_t q;
   state_t next_q;

   logic access;
   logic done;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic hit;
   logic [7:0] rd;
   logic clk_on;
   logic int_tick;
   logic tin_fall;
   logic edge_b_fall;
   logic [1:0] src;
   logic [1:0] pre_end;
   logic [1:0] cnt_end;
   logic [1:0] load;
   logic [3:0] req;
   logic found;
   logic [1:0] win;
   logic [1:0] sl;
   logic wd_count;
   logic wd_fire;
   tin_mode_t tin_mode;

   function automatic state_t init_state();
      state_t s;
      s = '0;
      s.tmode = `TMODE_RESET;
      s.oe = ~`P2DIR_RESET;
      s.irq = `IRQ_RESET;
      s.mask = `MASK_RESET;
      s.sleep = SLEEP_RUN;
      s.run_out = 1'b1;
      s.tin_prev = 1'b1;
      s.edge_b_prev = 1'b1;
      return s;
   endfunction

   function automatic logic [3:0] vec_of(input logic [1:0] s);
      case (s)
         2'd0: vec_of = `VEC_EDGE_B;
         2'd1: vec_of = `VEC_EDGE_A;
         2'd2: vec_of = `VEC_CNT0;
         default: vec_of = `VEC_CNT1;
      endcase
   endfunction

   // Next-state logic for the bus slave, counters, interrupts, sleep and watchdog.
   always_comb begin
      next_q = q;
      access = psel && penable;
      done = access && q.ready;
      wr = done && pwrite && !q.err;
      idx = paddr[9:2];
      wbyte = pwdata[7:0];
      tin_mode = tin_mode_t'(q.tmode[`TMODE_TIN_HI:`TMODE_TIN_LO]);
      clk_on = (q.sleep != SLEEP_STOP);
      tin_fall = q.tin_prev && !timer_input_pin;
      edge_b_fall = q.edge_b_prev && !second_edge_irq_pin;
      hit = 1'b1;
      rd = 8'h00;

      // Register decode; a read never alters a counter.
      case (idx)
         `TMODE_IDX: rd = q.tmode;
         `CNT1_IDX: rd = q.cnt[1];
         `CNT0_IDX: rd = q.cnt[0];
         `IRQ_IDX: rd = q.irq;
         `MASK_IDX: rd = q.mask;
         `STATUS_IDX: rd = {3'b000, q.wdh_on, q.wdt_on, q.wake_armed, q.sleep};
         `P2DATA_IDX: rd = q.port_out;
         `PSC1_IDX, `PSC0_IDX, `P2DIR_IDX, `PRIO_IDX, `CMD_IDX: rd = 8'h00;
         default: hit = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:10] != '0) begin
         hit = 1'b0;
      end

      // APB answer one cycle after the access phase opens.
      next_q.ready = access && !q.ready;
      if (access && !q.ready) begin
         next_q.rdata = {24'h00_0000, rd};
         next_q.err = !hit;
      end else begin
         next_q.err = 1'b0;
      end

      next_q.tin_prev = timer_input_pin;
      next_q.edge_b_prev = second_edge_irq_pin;

      // Processor clock over four; frozen in STOP.
      next_q.div = clk_on ? q.div + 2'd1 : q.div;
      int_tick = clk_on && (q.div == 2'd3);

      // Counter clock sources and trigger starts.
      load = 2'b00;
      src[0] = int_tick;
      src[1] = int_tick;
      if (!q.pre[1][`PRE_SRC_INT]) begin
         case (tin_mode)
            TIN_EXT_CLOCK: src[1] = clk_on && tin_fall;
            TIN_GATE: src[1] = int_tick && timer_input_pin;
            TIN_TRIG_ONCE: load[1] = clk_on && tin_fall && !q.tmode[`TMODE_RUN1];
            TIN_TRIG_RETRIG: load[1] = clk_on && tin_fall;
            default: src[1] = int_tick;
         endcase
      end
      if (load[1]) begin
         next_q.tmode[`TMODE_RUN1] = 1'b1;
      end

      // Register writes; load bits act once and are not stored.
      if (wr) begin
         case (idx)
            `TMODE_IDX: begin
               next_q.tmode = wbyte & ~8'h05;
               load[0] = wbyte[`TMODE_LOAD0];
               load[1] = load[1] | wbyte[`TMODE_LOAD1];
            end
            `CNT1_IDX: next_q.init[1] = wbyte;
            `CNT0_IDX: next_q.init[0] = wbyte;
            `PSC1_IDX: next_q.pre[1] = wbyte;
            `PSC0_IDX: next_q.pre[0] = {wbyte[7:2], 1'b0, wbyte[0]};
            `P2DIR_IDX: next_q.oe = ~wbyte;
            `PRIO_IDX: next_q.prio = wbyte;
            `MASK_IDX: next_q.mask = wbyte;
            `IRQ_IDX: next_q.irq = {2'b00, wbyte[5:0]};
            `P2DATA_IDX: next_q.port_out = wbyte;
            default: next_q.tmode = next_q.tmode;
         endcase
      end

      // Prescalers and counters; zero in either means a full 64 or 256 count.
      pre_end = 2'b00;
      cnt_end = 2'b00;
      for (int t = 0; t < 2; t++) begin
         if (load[t]) begin
            next_q.cnt[t] = q.init[t];
            next_q.pcnt[t] = q.pre[t][`PRE_MOD_HI:`PRE_MOD_LO];
         end else if (src[t] && q.tmode[2*t+1]) begin
            pre_end[t] = (q.pcnt[t] == 6'd1);
            next_q.pcnt[t] = pre_end[t] ? q.pre[t][`PRE_MOD_HI:`PRE_MOD_LO] : q.pcnt[t] - 6'd1;
            if (pre_end[t]) begin
               cnt_end[t] = (q.cnt[t] == 8'd1);
               next_q.cnt[t] = q.cnt[t] - 8'd1;
               if (cnt_end[t] && q.pre[t][`PRE_CONT]) begin
                  next_q.cnt[t] = q.init[t];
               end else if (cnt_end[t]) begin
                  next_q.tmode[2*t+1] = 1'b0;
               end
            end
         end
      end

      // Priority pick among unmasked requests, rotated by the priority select.
      req = {q.irq[`IRQ_CNT1], q.irq[`IRQ_CNT0], q.irq[`IRQ_EDGE_A], q.irq[`IRQ_EDGE_B]} &
            {q.mask[`IRQ_CNT1], q.mask[`IRQ_CNT0], q.mask[`IRQ_EDGE_A], q.mask[`IRQ_EDGE_B]} &
            {4{q.mask[`MASK_GLOBAL]}};
      found = 1'b0;
      win = 2'd0;
      for (int k = 0; k < 4; k++) begin
         sl = q.prio[1:0] + 2'(k);
         if (!found && req[sl]) begin
            found = 1'b1;
            win = sl;
         end
      end
      next_q.int_request = found && (q.sleep != SLEEP_STOP) && !int_ack;
      next_q.slot = win;
      next_q.vector = vec_of(win);

      // Grant: drop the serviced bit and the global enable.
      if (int_ack && q.int_request) begin
         next_q.mask[`MASK_GLOBAL] = 1'b0;
         case (q.slot)
            2'd0: next_q.irq[`IRQ_EDGE_B] = 1'b0;
            2'd1: next_q.irq[`IRQ_EDGE_A] = 1'b0;
            2'd2: next_q.irq[`IRQ_CNT0] = 1'b0;
            default: next_q.irq[`IRQ_CNT1] = 1'b0;
         endcase
      end

      // Events set pending bits after any clear, whatever the mask.
      if (edge_b_fall) next_q.irq[`IRQ_EDGE_B] = 1'b1;
      if (tin_fall) next_q.irq[`IRQ_EDGE_A] = 1'b1;
      if (cnt_end[0]) next_q.irq[`IRQ_CNT0] = 1'b1;
      if (cnt_end[1]) next_q.irq[`IRQ_CNT1] = 1'b1;

      // Sleep control. The core flushes its pipeline before issuing these commands.
      case (q.sleep)
         SLEEP_RUN: begin
            if (wr && idx == `CMD_IDX && wbyte == `OP_HALT) begin
               next_q.sleep = SLEEP_HALT;
            end else if (wr && idx == `CMD_IDX && wbyte == `OP_STOP) begin
               next_q.sleep = SLEEP_STOP;
               next_q.wake_armed = !q.oe[`P2_WAKE_BIT];
               next_q.wake_cnt = 8'd0;
            end
         end
         SLEEP_HALT: begin
            if (found) begin
               next_q.sleep = SLEEP_RUN;
            end
         end
         SLEEP_STOP: begin
            if (!q.wake_armed || stop_wake_pin) begin
               next_q.wake_cnt = 8'd0;
            end else if (q.wake_cnt == 8'(WAKE_MIN_CYCLES - 1)) begin
               next_q.sleep = SLEEP_RUN;
               next_q.hold_cnt = 32'd1;
            end else begin
               next_q.wake_cnt = q.wake_cnt + 8'd1;
            end
         end
         default: next_q.sleep = SLEEP_RUN;
      endcase

      // Watchdog: started and cleared by its command, silent in STOP.
      if (wr && idx == `CMD_IDX && wbyte == `OP_WDT) begin
         next_q.wdt_on = 1'b1;
         next_q.wd_cnt = 32'd0;
      end else if (wr && idx == `CMD_IDX && wbyte == `OP_KEEP) begin
         next_q.wdh_on = 1'b1;
      end
      wd_count = q.wdt_on && (q.sleep == SLEEP_RUN || (q.sleep == SLEEP_HALT && q.wdh_on));
      wd_fire = wd_count && (q.wd_cnt == WDT_CYCLES - 1);
      if (wd_count && !(wr && idx == `CMD_IDX && wbyte == `OP_WDT)) begin
         next_q.wd_cnt = q.wd_cnt + 32'd1;
      end

      // Reset hold toward the core.
      if (q.hold_cnt != 32'd0) begin
         next_q.hold_cnt = next_q.hold_cnt - 32'd1;
      end
      if (wd_fire) begin
         next_q = init_state();
         next_q.hold_cnt = POR_CYCLES;
      end
      next_q.core_reset = (next_q.hold_cnt != 32'd0);
      next_q.run_out = (next_q.sleep == SLEEP_RUN);
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q <= init_state();
      end else begin
         q <= next_q;
      end
   end

   // Outputs come from the state register.
   assign prdata = q.rdata;
   assign pready = q.ready;
   assign pslverr = q.err;
   assign int_request = q.int_request;
   assign int_vector = q.vector;
   assign cpu_clock_run = q.run_out;
   assign core_reset = q.core_reset;
   assign port_two_out = q.port_out;
   assign port_two_oe = q.oe;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   halt_clock_a: assert property (wr && idx == `CMD_IDX && wbyte == `OP_HALT && q.sleep == SLEEP_RUN && !wd_fire
                                  |=> !q.run_out)
      else $error("cpu clock still running after halt command");
   halt_exit_a: assert property (q.sleep == SLEEP_HALT && found && !wd_fire |=> q.sleep == SLEEP_RUN)
      else $error("enabled interrupt did not end halt");
   mask_global_a: assert property (!q.mask[`MASK_GLOBAL] |=> !q.int_request)
      else $error("request raised with global mask off");
   grant_disable_a: assert property (int_ack && q.int_request && !wd_fire |=> !q.mask[`MASK_GLOBAL])
      else $error("grant left interrupts enabled");
   vector_map_a: assert property (q.int_request |-> q.vector == vec_of(q.slot))
      else $error("vector does not match source");
   poll_latch_a: assert property (tin_fall && !wd_fire |=> q.irq[`IRQ_EDGE_A])
      else $error("masked edge not latched for polling");
   stop_wdt_a: assert property (q.sleep == SLEEP_STOP |=> $stable(q.wd_cnt))
      else $error("watchdog moved during stop");
   stop_ports_a: assert property (q.sleep == SLEEP_STOP |=> $stable(port_two_out) && $stable(port_two_oe))
      else $error("outputs changed during stop");
   wdt_fire_a: assert property (wd_fire |=> core_reset ##1 core_reset)
      else $error("watchdog timeout gave no reset");
   wdt_sticky_a: assert property (q.wdt_on && !wd_fire |=> q.wdt_on)
      else $error("watchdog disabled without reset");
   single_pass_a: assert property (cnt_end[0] && !q.pre[0][`PRE_CONT] && !wd_fire && !wr
                                   |=> !q.tmode[`TMODE_RUN0] && q.cnt[0] == 8'd0)
      else $error("single pass counter did not halt at zero");

endmodule
`default_nettype wire

// file: sim/tb_timer_irq_sleep_watchdog.sv
`include "sysctl_params.svh"
`default_nettype none
module tb_timer_irq_sleep_watchdog import sysctl_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // Shortened watchdog and reset counts keep the run brief.
   localparam int WDT = 200;
   localparam int POR = 20;
   localparam int WAKE = 4;
   localparam int SB[4] = '{1, 2, 4, 5};
   localparam int VV[4] = '{2, 4, 8, 10};
   logic clk_sys, rst_n, psel, penable, pwrite, int_ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, int_request, cpu_clock_run, core_reset;
   logic timer_input_pin, second_edge_irq_pin, stop_wake_pin;
   logic [3:0] int_vector;
   logic [7:0] port_two_out, port_two_oe;
   int num_errors = 0;
   int n_checks = 0;
   int rst_seen = 0;

   sysctl_core #(.ADDR_W(12), .WDT_CYCLES(WDT), .POR_CYCLES(POR), .WAKE_MIN_CYCLES(WAKE)) sysctl_core_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
      .second_edge_irq_pin(second_edge_irq_pin), .stop_wake_pin(stop_wake_pin), .int_ack(int_ack),
      .int_request(int_request), .int_vector(int_vector), .cpu_clock_run(cpu_clock_run),
      .core_reset(core_reset), .port_two_out(port_two_out), .port_two_oe(port_two_oe));

   // The clock toggles every half period of 2.5 ns.
   always #2.5 clk_sys = ~clk_sys;

   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Waits a number of cycles and counts cycles with the core held in reset.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         if (core_reset === 1'b1) rst_seen++;
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                      output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps the next setup from driving psel again in this time step.
      @(posedge clk_sys);
      if (n >= 20) begin
         num_errors++;
         $display("Error apb expected pready seen none");
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      check(what, {24'h00_0000, r}, {24'h00_0000, exp});
   endtask

   // Waits, within a bound, for int_request (0), cpu_clock_run (1) or core_reset (2) to reach a level.
   task automatic wait_out(input int sel, input logic lvl, input int bound);
      int n;
      for (n = 0; n < bound; n++) begin
         @(posedge clk_sys);
         if ((sel == 0 ? int_request : sel == 1 ? cpu_clock_run : core_reset) === lvl) break;
      end
      if (n >= bound) begin
         num_errors++;
         $display("Error wait %0d expected %b seen timeout", sel, lvl);
         report_and_stop();
      end
   endtask

   // Grants the pending interrupt with a one-cycle acknowledge.
   task automatic ack();
      int_ack <= 1'b1;
      @(posedge clk_sys);
      int_ack <= 1'b0;
      idle(2);
   endtask

   task automatic test_reset_values();
      logic [7:0] r;
      logic e;
      rd_chk("timer mode", `TMODE_IDX, `TMODE_RESET);
      rd_chk("pending", `IRQ_IDX, `IRQ_RESET);
      rd_chk("mask", `MASK_IDX, `MASK_RESET);
      rd_chk("prescaler read", `PSC0_IDX, 8'h00);
      apb(1'b0, 8'h10, 8'h00, r, e);
      check("unmapped error", {31'h0, e}, 32'h0000_0001);
      check("oe at reset", port_two_oe, 32'h0000_0000);
   endtask

   // Every source yields its own vector; a grant clears its pending bit and the global enable.
   task automatic test_vectors();
      for (int i = 0; i < 4; i++) begin
         wr(`IRQ_IDX, 8'(1 << SB[i]));
         wr(`MASK_IDX, 8'(8'h80 | (1 << SB[i])));
         wait_out(0, 1'b1, 10);
         check("vector", int_vector, VV[i]);
         ack();
         check("request after grant", int_request, 32'h0000_0000);
         rd_chk("pending after grant", `IRQ_IDX, 8'h00);
         rd_chk("mask after grant", `MASK_IDX, 8'(1 << SB[i]));
      end
      // Without the global bit nothing is requested, yet the bit stays pending.
      wr(`IRQ_IDX, 8'h02);
      idle(6);
      check("masked request", int_request, 32'h0000_0000);
      rd_chk("polled pending", `IRQ_IDX, 8'h02);
   endtask

   // Each priority setting starts the search at a different slot.
   task automatic test_priority();
      for (int p = 0; p < 4; p++) begin
         wr(`MASK_IDX, 8'h00);
         wr(`IRQ_IDX, 8'h36);
         wr(`PRIO_IDX, 8'(p));
         wr(`MASK_IDX, 8'hb6);
         wait_out(0, 1'b1, 10);
         check("priority vector", int_vector, VV[p]);
         ack();
         rd_chk("pending left", `IRQ_IDX, 8'(8'h36 & ~(1 << SB[p])));
      end
      wr(`IRQ_IDX, 8'h00);
   endtask

   // Runs one counter from the internal clock at divide by one and polls its request.
   task automatic test_counter(input logic [7:0] cidx, input logic [7:0] pidx, input logic [7:0] pre,
                               input logic [7:0] tmr, input int b);
      logic [7:0] r;
      logic e;
      wr(`MASK_IDX, 8'h00);
      wr(pidx, pre);
      wr(cidx, 8'h03);
      for (int k = 0; k < 2; k++) begin
         // Each pass restarts the counter from its initial value.
         wr(`TMODE_IDX, tmr);
         for (int n = 0; n < 40; n++) begin
            apb(1'b0, `IRQ_IDX, 8'h00, r, e);
            if (r[b] === 1'b1) break;
         end
         check("counter end request", r[b], 32'h0000_0001);
         wr(`IRQ_IDX, 8'h00);
         idle(60);
         apb(1'b0, `IRQ_IDX, 8'h00, r, e);
         check("reload behaviour", r[b], {31'h0, pre[0]});
         wr(`IRQ_IDX, 8'h00);
      end
      wr(`TMODE_IDX, 8'h00);
      wr(`IRQ_IDX, 8'h00);
   endtask

   // Counter one counts falling edges of the timer input when the external source is picked.
   task automatic test_ext_clock();
      logic [7:0] r;
      logic e;
      wr(`PSC1_IDX, 8'h05);
      wr(`CNT1_IDX, 8'h02);
      wr(`TMODE_IDX, 8'h0c);
      for (int k = 0; k < 2; k++) begin
         timer_input_pin <= 1'b0;
         idle(2);
         timer_input_pin <= 1'b1;
         idle(2);
         if (k == 0) rd_chk("count after one edge", `CNT1_IDX, 8'h01);
      end
      apb(1'b0, `IRQ_IDX, 8'h00, r, e);
      check("external clock request", r[`IRQ_CNT1], 32'h0000_0001);
      wr(`TMODE_IDX, 8'h00);
      wr(`IRQ_IDX, 8'h00);
   endtask

   // HALT stops the CPU clock, holds the port lines and ends on an enabled edge request.
   task automatic test_halt();
      wr(`P2DIR_IDX, 8'h00);
      wr(`P2DATA_IDX, 8'ha5);
      wr(`MASK_IDX, 8'h82);
      wr(`CMD_IDX, `OP_HALT);
      wait_out(1, 1'b0, 10);
      idle(20);
      check("halted", cpu_clock_run, 32'h0000_0000);
      second_edge_irq_pin <= 1'b0;
      wait_out(1, 1'b1, 10);
      check("port out in halt", port_two_out, 32'h0000_00a5);
      check("port oe in halt", port_two_oe, 32'h0000_00ff);
      check("edge request", int_request, 32'h0000_0001);
      ack();
      second_edge_irq_pin <= 1'b1;
   endtask

   // STOP ignores a short wake pulse, ends on a long one and keeps the port setup.
   task automatic test_stop();
      wr(`P2DIR_IDX, 8'h80);
      wr(`CMD_IDX, `OP_STOP);
      wait_out(1, 1'b0, 10);
      stop_wake_pin <= 1'b0;
      idle(WAKE - 2);
      stop_wake_pin <= 1'b1;
      idle(10);
      check("short wake pulse", cpu_clock_run, 32'h0000_0000);
      stop_wake_pin <= 1'b0;
      idle(WAKE + 2);
      stop_wake_pin <= 1'b1;
      wait_out(1, 1'b1, 20);
      idle(4);
      check("oe after wake", port_two_oe, 32'h0000_007f);
      check("out after wake", port_two_out, 32'h0000_00a5);
   endtask

   // The watchdog is refreshed, sleeps through STOP, then times out into a full reset.
   task automatic test_watchdog();
      int n;
      wr(`MASK_IDX, 8'h04);
      wr(8'he0, `OP_WDT);
      rst_seen = 0;
      repeat (4) begin
         idle(WDT / 2);
         wr(8'he0, `OP_WDT);
      end
      wr(8'he0, `OP_STOP);
      idle(3 * WDT);
      check("no reset when refreshed or stopped", rst_seen, 32'h0000_0000);
      stop_wake_pin <= 1'b0;
      idle(WAKE + 2);
      stop_wake_pin <= 1'b1;
      wait_out(1, 1'b1, 20);
      idle(4);
      wait_out(2, 1'b1, 2 * WDT);
      n = 1;
      while (n < 4 * POR) begin
         @(posedge clk_sys);
         if (core_reset !== 1'b1) break;
         n++;
      end
      check("reset length", n, POR);
      rd_chk("mask after timeout", `MASK_IDX, `MASK_RESET);
      check("oe after timeout", port_two_oe, 32'h0000_0000);
      // With the keepalive on, the watchdog counts through HALT and its reset ends the halt.
      wr(`CMD_IDX, `OP_WDT);
      wr(`CMD_IDX, `OP_KEEP);
      wr(`CMD_IDX, `OP_HALT);
      wait_out(1, 1'b0, 10);
      wait_out(2, 1'b1, 2 * WDT);
      check("clock after halt timeout", cpu_clock_run, 32'h0000_0001);
   endtask

   // Drives idle inputs, holds reset for 20 cycles and runs every scenario.
   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      int_ack = 1'b0;
      timer_input_pin = 1'b1;
      second_edge_irq_pin = 1'b1;
      stop_wake_pin = 1'b1;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      test_reset_values();
      test_vectors();
      test_priority();
      test_counter(`CNT0_IDX, `PSC0_IDX, 8'h04, 8'h03, `IRQ_CNT0);
      test_counter(`CNT1_IDX, `PSC1_IDX, 8'h07, 8'h0c, `IRQ_CNT1);
      test_ext_clock();
      test_halt();
      test_stop();
      test_watchdog();
      report_and_stop();
   end
endmodule
`default_nettype wire
